// File: hw/rdsw_pkg.sv
// Package: status word layout, mode encodings and widths for the status writer
package rdsw_pkg;

  localparam int unsigned RDSW_OWN_BIT     = 31;
  localparam int unsigned RDSW_FL_HI       = 30;
  localparam int unsigned RDSW_FL_LO       = 16;
  localparam int unsigned RDSW_FL_W        = 15;
  localparam int unsigned RDSW_ES_BIT      = 15;
  localparam int unsigned RDSW_LE_BIT      = 14;
  localparam int unsigned RDSW_DT_HI       = 13;
  localparam int unsigned RDSW_DT_LO       = 12;
  localparam int unsigned RDSW_RUNT_BIT    = 11;
  localparam int unsigned RDSW_MC_BIT      = 10;
  localparam int unsigned RDSW_FIRST_BIT   = 9;
  localparam int unsigned RDSW_LAST_BIT    = 8;
  localparam int unsigned RDSW_TL_BIT      = 7;
  localparam int unsigned RDSW_CS_BIT      = 6;
  localparam int unsigned RDSW_WD_BIT      = 4;
  localparam int unsigned RDSW_DB_BIT      = 2;
  localparam int unsigned RDSW_CE_BIT      = 1;
  localparam int unsigned RDSW_OF_BIT      = 0;

  // Operating mode register fields
  localparam int unsigned RDSW_OM_HI       = 11;
  localparam int unsigned RDSW_OM_LO       = 10;
  localparam int unsigned RDSW_PB_BIT      = 3;

  // Register port
  localparam logic [7:0]  RDSW_ADDR_MODE   = 8'h00;
  localparam logic [7:0]  RDSW_ADDR_STAT   = 8'h04;
  localparam logic [7:0]  RDSW_ADDR_CNT    = 8'h08;
  localparam logic [31:0] RDSW_MODE_RST    = 32'h0000_0000;

  localparam int unsigned RDSW_FIFO_DEPTH  = 2;
  localparam int unsigned RDSW_WORD_W      = 32;

  // Operating mode codes
  localparam logic [1:0]  RDSW_OM_NORMAL   = 2'h0;
  localparam logic [1:0]  RDSW_OM_INT_LB   = 2'h1;
  localparam logic [1:0]  RDSW_OM_EXT_LB   = 2'h2;
  localparam logic [1:0]  RDSW_OM_RSVD     = 2'h3;

  // Data type codes written to the status word
  localparam logic [1:0]  RDSW_DT_SERIAL   = 2'h0;
  localparam logic [1:0]  RDSW_DT_INT_LB   = 2'h1;
  localparam logic [1:0]  RDSW_DT_EXT_LB   = 2'h2;

  typedef enum logic [1:0] {
    RDSW_ST_IDLE  = 2'b00,
    RDSW_ST_WRITE = 2'b01,
    RDSW_ST_DROP  = 2'b10
  } rdsw_state_t;

endpackage

// File: hw/rdsw_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module rdsw_skid
  import rdsw_pkg::*;
#(
  parameter int unsigned WIDTH = RDSW_WORD_W,
  parameter int unsigned DEPTH = RDSW_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } rdsw_skid_st_t;

  rdsw_skid_st_t   st_r;
  rdsw_skid_st_t   st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];

  logic push;
  logic pop;

  assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[st_r.rp];

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + AW'(1);
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + AW'(1);
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (push) begin
      mem_r[st_r.wp] <= in_data;
    end
  end

endmodule

// File: hw/rdsw_mode_reg.sv
// Operating mode register with plain read and write port
`timescale 1ns/1ps
module rdsw_mode_reg
  import rdsw_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Status shown to software
  input  wire logic [31:0] stat_word,
  input  wire logic [15:0] frame_cnt,
  // Mode to the writer
  output logic [31:0]      mode_word
);

  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] rdata;
  } rdsw_reg_st_t;

  rdsw_reg_st_t st_r;
  rdsw_reg_st_t st_nxt;

  assign mode_word = st_r.mode;
  assign reg_rdata = st_r.rdata;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = '0;
    if (reg_wr && reg_addr == RDSW_ADDR_MODE) begin
      st_nxt.mode = reg_wdata;
    end
    if (reg_rd) begin
      if (reg_addr == RDSW_ADDR_MODE) begin
        st_nxt.rdata = st_r.mode;
      end else if (reg_addr == RDSW_ADDR_STAT) begin
        st_nxt.rdata = stat_word;
      end else if (reg_addr == RDSW_ADDR_CNT) begin
        st_nxt.rdata = {16'h0000, frame_cnt};
      end else begin
        st_nxt.rdata = '0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= {RDSW_MODE_RST, 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// File: hw/rdsw_writer.sv
// Receive status word builder: closes descriptors and writes their first word
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

// Summary of operation
// [R1] Bit 31 set means device owns descriptor
// [R2] Clear ownership at frame end or full
// [R3] Length field holds byte count with CRC
// [R4] Length valid only last, no length error
// [R5] Error summary ORs six error flags
// [R6] Summary, type, multicast valid only last
// [R7] Length error when next descriptor unavailable
// [R8] Data type encodes serial or loopback
// [R9] Data type follows operating mode field
// [R10] Runt flag for early collision or end
// [R11] Runt frames delivered only if pass-bad; here only single-descriptor runts are dropped
// [R12] Runt valid only last and no overflow
// [R13] Multicast flag for multicast destination
// [R14] Last flag on frame's final descriptor
// [R15] First flag on frame's first descriptor
// [R16] Overflow flag on FIFO truncation
// [R17] Status written with ownership release
// [R18] Touch descriptor only while owned
module rdsw_writer
  import rdsw_pkg::*;
#(
  parameter int unsigned FL_W = RDSW_FL_W
) (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  // Register port
  input  wire logic [7:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [31:0]          reg_rdata,
  // Descriptor close request from the receive path
  input  wire logic            close_valid,
  output logic                 close_ready,
  input  wire logic            close_last,
  input  wire logic [FL_W-1:0] close_len,
  input  wire logic            close_fifo_ovf,
  input  wire logic            close_crc_err,
  input  wire logic            close_coll_seen,
  input  wire logic            close_too_long,
  input  wire logic            close_early_end,
  input  wire logic            close_next_free,
  input  wire logic            close_multicast,
  input  wire logic            close_watchdog,
  input  wire logic            close_dribble,
  // Ownership word read back from the descriptor being closed
  input  wire logic            desc_own,
  // Status word write to host memory
  output logic                 sw_valid,
  input  wire logic            sw_ready,
  output logic [31:0]          sw_data,
  // Frame discard indication
  output logic                 drop_pulse
);

  typedef struct packed {
    rdsw_state_t state;
    logic        in_frame;
    logic [31:0] word;
    logic [31:0] last_word;
    logic [15:0] frame_cnt;
    logic        drop;
  } rdsw_st_t;

  rdsw_st_t    st_r;
  rdsw_st_t    st_nxt;
  logic [31:0] mode_word;
  logic        fifo_in_ready;
  logic        fifo_in_valid;
  logic [1:0]  dt_code;
  logic        runt;
  logic        len_err;
  logic [31:0] built;

  // Mode field maps straight to the data type; reserved mode gives the serial type
  function automatic logic [1:0] mode_to_dt(input logic [1:0] om);
    case (om)
      RDSW_OM_INT_LB: mode_to_dt = RDSW_DT_INT_LB;
      RDSW_OM_EXT_LB: mode_to_dt = RDSW_DT_EXT_LB;
      default:        mode_to_dt = RDSW_DT_SERIAL;
    endcase
  endfunction

  rdsw_mode_reg u_regs (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .stat_word (st_r.last_word),
    .frame_cnt (st_r.frame_cnt),
    .mode_word (mode_word)
  );

  assign dt_code = mode_to_dt(mode_word[RDSW_OM_HI:RDSW_OM_LO]); // [R8] [R9]
  // Damage before the collision window; a late collision is seen separately
  assign runt    = close_early_end && !close_fifo_ovf; // [R10] [R12]
  assign len_err = !close_last && !close_next_free; // [R7]

  always_comb begin
    built = '0;
    built[RDSW_OWN_BIT]   = 1'b0; // [R1] [R2]
    built[RDSW_FIRST_BIT] = !st_r.in_frame; // [R15]
    // A length error ends the frame in this descriptor
    built[RDSW_LAST_BIT]  = close_last || len_err; // [R14]
    built[RDSW_OF_BIT]    = close_fifo_ovf; // [R16]
    if (close_last || len_err) begin
      // Length field kept clear when a length error made it meaningless
      if (!len_err) begin
        built[RDSW_FL_HI:RDSW_FL_LO] = RDSW_FL_W'(close_len); // [R3] [R4]
      end
      built[RDSW_LE_BIT]          = len_err; // [R7]
      built[RDSW_DT_HI:RDSW_DT_LO] = dt_code; // [R6] [R8]
      built[RDSW_RUNT_BIT]        = runt; // [R10] [R12]
      built[RDSW_MC_BIT]          = close_multicast; // [R13] [R6]
      built[RDSW_TL_BIT]          = close_too_long;
      built[RDSW_CS_BIT]          = close_coll_seen;
      built[RDSW_WD_BIT]          = close_watchdog;
      built[RDSW_DB_BIT]          = close_dribble && !close_coll_seen && !runt;
      built[RDSW_CE_BIT]          = close_crc_err;
      built[RDSW_ES_BIT]          = close_fifo_ovf | close_crc_err | close_coll_seen
                                  | close_too_long | runt | len_err; // [R5] [R6]
    end
  end

  // Only take a close while idle and the owning bit says the device holds it
  assign close_ready   = (st_r.state == RDSW_ST_IDLE) && desc_own; // [R18]
  assign fifo_in_valid = (st_r.state == RDSW_ST_WRITE);
  assign drop_pulse    = st_r.drop;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.drop = 1'b0;
    case (st_r.state)
      RDSW_ST_IDLE: begin
        if (close_valid && close_ready) begin
          // Single-descriptor runt frames are dropped unless pass-bad is set
          if (runt && close_last && !st_r.in_frame && !mode_word[RDSW_PB_BIT]) begin
            st_nxt.state = RDSW_ST_DROP; // [R11]
          end else begin
            st_nxt.word  = built; // [R17]
            st_nxt.state = RDSW_ST_WRITE;
          end
          st_nxt.in_frame = !(close_last || len_err);
        end
      end
      RDSW_ST_WRITE: begin
        // Whole word, ownership clear included, goes out in one beat
        if (fifo_in_ready) begin
          st_nxt.last_word = st_r.word; // [R17]
          st_nxt.state     = RDSW_ST_IDLE;
          if (st_r.word[RDSW_LAST_BIT]) begin
            st_nxt.frame_cnt = st_r.frame_cnt + 16'h0001;
          end
        end
      end
      RDSW_ST_DROP: begin
        st_nxt.drop  = 1'b1; // [R11]
        st_nxt.state = RDSW_ST_IDLE;
      end
      default: begin
        st_nxt.state = RDSW_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= '{state: RDSW_ST_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  rdsw_skid #(
    .WIDTH (RDSW_WORD_W),
    .DEPTH (RDSW_FIFO_DEPTH)
  ) u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (st_r.word),
    .out_valid (sw_valid),
    .out_ready (sw_ready),
    .out_data  (sw_data)
  );

endmodule

// File: testbench/rdsw_writer_asserts.sv
// Checker on the status writer ports
`timescale 1ns/1ps
module rdsw_writer_asserts (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Close side
  input wire logic        close_valid,
  input wire logic        close_ready,
  input wire logic        desc_own,
  // Status word side
  input wire logic        sw_valid,
  input wire logic        sw_ready,
  input wire logic [31:0] sw_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; close_valid && close_ready; endsequence
  sequence s_last; sw_valid && sw_data[8]; endsequence
  property p_own; sw_valid |-> !sw_data[31]; endproperty
  property p_hold; sw_valid && !sw_ready |=> sw_valid && $stable(sw_data); endproperty
  property p_es; s_last |-> sw_data[15] == |{sw_data[14], sw_data[11], sw_data[7:6], sw_data[1:0]};
  endproperty
  property p_dt; sw_valid |-> sw_data[13:12] != 2'h3; endproperty
  property p_le; sw_valid && sw_data[14] |-> sw_data[8] && sw_data[30:16] == 15'h0; endproperty
  property p_ready; close_ready |-> desc_own; endproperty
  property p_take; s_take |=> !close_ready; endproperty
  property p_rf; sw_valid && sw_data[11] |-> !sw_data[0]; endproperty
  property p_mid; sw_valid && !sw_data[8] |-> sw_data[30:10] == 21'h0; endproperty
  a_own: assert property (p_own) else $error("owned word");
  a_hold: assert property (p_hold) else $error("word changed in stall");
  a_es: assert property (p_es) else $error("summary wrong");
  a_dt: assert property (p_dt) else $error("reserved type");
  a_le: assert property (p_le) else $error("length error word");
  a_ready: assert property (p_ready) else $error("ready unowned");
  a_take: assert property (p_take) else $error("ready after take");
  a_rf: assert property (p_rf) else $error("runt with overflow");
  a_mid: assert property (p_mid) else $error("middle word fields");
endmodule
bind rdsw_writer rdsw_writer_asserts i_rdsw_writer_asserts (.core_clk, .rst_n, .close_valid,
  .close_ready, .desc_own, .sw_valid, .sw_ready, .sw_data);

// File: testbench/rdsw_host_model.sv
// Host side: accepts status words and hands descriptors back
`timescale 1ns/1ps
module rdsw_host_model (
  // Clock
  input wire logic        core_clk,
  // Status word stream
  input wire logic        sw_valid,
  output logic            sw_ready,
  input wire logic [31:0] sw_data,
  // Bench control
  input wire logic        stall,
  input wire logic [1:0]  coin,
  output logic            desc_own,
  output logic            got,
  output logic [31:0]     got_word
);
  initial begin
    sw_ready = 1'b0;
    desc_own = 1'b1;
    got = 1'b0;
    got_word = 32'h0;
  end
  always @(posedge core_clk) begin
    sw_ready <= !stall && coin[0];
    desc_own <= coin != 2'h0;
    got <= sw_valid && sw_ready && !sw_data[31];
    got_word <= sw_data;
  end
endmodule

// File: testbench/test_rx_descriptor_status_writer.sv
// Bench for the receive status word writer
`timescale 1ns/1ps
module test_rx_descriptor_status_writer;
  import rdsw_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        close_valid = 1'b0;
  logic        close_ready;
  logic [9:0]  cf = 10'h0;
  logic [14:0] close_len = 15'h0;
  logic        desc_own, sw_valid, sw_ready, drop_pulse, got;
  logic [31:0] sw_data, got_word;
  logic        stall = 1'b0;
  logic [1:0]  coin = 2'h0;
  logic [1:0]  mode = 2'h0;
  logic        pb = 1'b0;
  logic        first = 1'b1;
  logic [31:0] q[$];
  int unsigned x = 13;
  int unsigned y = 13;
  int          fails = 0;
  int          checked = 0;
  int          cyc = 0;
  int          drops = 0;
  int          exp_drops = 0;
  int          exp_frames = 0;
  logic [31:0] exp_last = 32'h0;

  rdsw_writer i_rdsw_writer (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .close_valid, .close_ready, .close_last(cf[0]), .close_len,
    .close_fifo_ovf(cf[1]), .close_crc_err(cf[2]), .close_coll_seen(cf[3]),
    .close_too_long(cf[4]), .close_early_end(cf[5]), .close_next_free(cf[6]),
    .close_multicast(cf[7]), .close_watchdog(cf[8]), .close_dribble(cf[9]), .desc_own,
    .sw_valid, .sw_ready, .sw_data, .drop_pulse);
  rdsw_host_model i_rdsw_host_model (.core_clk, .sw_valid, .sw_ready, .sw_data, .stall,
    .coin, .desc_own, .got, .got_word);

  function automatic int unsigned xs(int unsigned v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Expected word, or an expected discard for a lone runt
  function automatic void model(logic [9:0] f, logic [14:0] n);
    logic le, ls, rf, es, db;
    logic [1:0] dt;
    le = !f[0] && !f[6];
    ls = f[0] || le;
    rf = f[5] && !f[1];
    es = f[1] | f[2] | f[3] | f[4] | rf | le;
    db = f[9] && !f[3] && !rf;
    dt = (mode == 2'h3) ? 2'h0 : mode;
    // Only a lone runt that really ends here is discarded; a truncated one is written
    if (f[0] && first && rf && !pb)
      exp_drops++;
    else if (ls) begin
      exp_frames++;
      q.push_back({1'b0, le ? 15'h0 : n, es, le, dt, rf, f[7], first, 1'b1, f[4], f[3], 1'b0,
        f[8], 1'b0, db, f[2], f[1]});
    end else
      q.push_back({22'h0, first, 8'h0, f[1]});
    if (q.size() > 0) exp_last = q[$];
    first = ls;
  endfunction

  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
    @(posedge core_clk);
  endtask

  task automatic cl(logic [9:0] f, logic [14:0] n);
    int w;
    w = 0;
    cf <= f;
    close_len <= n;
    close_valid <= 1'b1;
    @(negedge core_clk);
    while (close_ready !== 1'b1 && w < 200) begin
      @(negedge core_clk);
      w++;
    end
    if (w == 200) fails++;
    @(posedge core_clk);
    close_valid <= 1'b0;
    model(f, n);
    @(posedge core_clk);
  endtask

  always #10 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    y = xs(y);
    coin <= y[1:0];
    cyc++;
    if (drop_pulse === 1'b1) drops++;
    if (got === 1'b1)
      chk("status word", (q.size() > 0) ? q.pop_front() : 32'hffffffff, got_word);
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(RDSW_ADDR_MODE, RDSW_MODE_RST, "mode reset");
    rd(8'h10, 32'h0, "unmapped");
    for (int m = 0; m < 8; m++) begin
      mode = m[1:0];
      pb = m[2];
      wr(RDSW_ADDR_MODE, {20'h0, mode, 6'h0, pb, 3'h0});
      rd(RDSW_ADDR_MODE, {20'h0, mode, 6'h0, pb, 3'h0}, "mode");
      if (m == 4) begin
        stall <= 1'b1;
        cl(10'h041, 15'h0040);
        cl(10'h041, 15'h7fff);
        repeat (30) @(posedge core_clk);
        chk("held valid", 32'h1, {31'h0, sw_valid});
        stall <= 1'b0;
      end
      for (int i = 0; i < 12; i++) begin
        x = xs(x);
        cl(x[9:0] | {3'h0, x[11], 5'h0, x[10]}, x[26:12]);
      end
    end
    repeat (80) @(posedge core_clk);
    chk("words left", 32'h0, q.size());
    chk("discards", exp_drops, drops);
    rd(RDSW_ADDR_STAT, exp_last, "last status");
    rd(RDSW_ADDR_CNT, {16'h0, exp_frames[15:0]}, "frame count");
    test_done();
  end
endmodule
